// [verilog/ref_prio_consts.svh]
`ifndef REF_PRIO_CONSTS_SVH
`define REF_PRIO_CONSTS_SVH
`define ADDR_PRIO_11_12 8'h1d
`define ADDR_PRIO_13_14 8'h1e
`define RST_MAIN_11_12_MASTER 8'hdc
`define RST_MAIN_11_12_SLAVE 8'hd1
`define RST_AUX_11_12 8'h00
`define RST_MAIN_13_14 8'hfe
`define RST_AUX_13_14 8'h00
`define PRIO_MASTER 4'hc
`define PRIO_SLAVE 4'h1
`define PRIO_OFF 4'h0
`define NUM_INPUTS 4
`define FIRST_INPUT 4'hb
`endif

// [verilog/ref_prio_pkg.sv]
package ref_prio_pkg;
  typedef struct packed {
    logic [3:0] hi;
    logic [3:0] lo;
  } prio_pair_t;
  typedef struct packed {
    prio_pair_t p13_14;
    prio_pair_t p11_12;
  } prio_bank_t;
  typedef enum logic [1:0] {
    ph_hold = 2'b01,
    ph_run = 2'b10
  } phase_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic aux;
    logic [7:0] addr;
    logic [7:0] data;
  } host_req_t;
  typedef struct packed {
    logic valid;
    logic [3:0] index;
  } sel_result_t;
endpackage

// [verilog/input_reference_priority_config.sv]
`timescale 1ns/1ps
`include "ref_prio_consts.svh"
// Contract
// - Smaller nonzero priority ranks an input higher during automatic selection.
// - Priority zero excludes the input; one to fifteen are valid levels.
// - Bank select bit low: accesses reach the main timing path copy.
// - Bank select bit high: accesses reach the auxiliary timing path copy.
// - Input 11 main default is 12 with master strap, 1 with slave.
// - Address 1d: input 12 in bits 7:4, input 11 in bits 3:0.
// - Address 1e: inputs 14/13; resets fe main, 00 auxiliary.
module input_reference_priority_config
  import ref_prio_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic master_slave_strap_in,
  input wire logic path_bank_select_in,
  input wire logic [7:0] addr_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] wr_data_in,
  output logic [7:0] rd_data_out,
  output logic main_sel_valid_out,
  output logic [3:0] main_sel_index_out,
  output logic aux_sel_valid_out,
  output logic [3:0] aux_sel_index_out
);
  host_req_t req;
  phase_t phase_q;
  phase_t phase_d;
  logic strap_load;
  logic [3:0] strap_prio;
  logic hit_a;
  logic hit_b;
  logic main_wr;
  logic aux_wr;
  prio_bank_t main_bank;
  prio_bank_t aux_bank;
  sel_result_t main_pick;
  sel_result_t aux_pick;
  logic [7:0] rd_word;

  assign req = '{wr: wr_en_in,
                 rd: rd_en_in,
                 aux: path_bank_select_in,
                 addr: addr_in,
                 data: wr_data_in};

  // Strap is taken once, on the first edge after reset is released
  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      ph_hold: begin
        phase_d = ph_run;
      end
      ph_run: begin
        phase_d = ph_run;
      end
      default: begin
        phase_d = ph_hold;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      phase_q <= ph_hold;
    end else begin
      phase_q <= phase_d;
    end
  end

  assign strap_load = (phase_q == ph_hold);
  assign strap_prio = master_slave_strap_in ? `PRIO_MASTER
                                            : `PRIO_SLAVE;

  assign hit_a = (req.addr == `ADDR_PRIO_11_12);
  assign hit_b = (req.addr == `ADDR_PRIO_13_14);

  // Writes in the strap cycle are dropped on both paths
  assign main_wr = req.wr && !req.aux && !strap_load;
  assign aux_wr = req.wr && req.aux && !strap_load;

  prio_copy #(
    .RST_11_12(`RST_MAIN_11_12_SLAVE),
    .RST_13_14(`RST_MAIN_13_14),
    .USE_STRAP(1'b1)
  ) u_main_copy (
    .clk_in(sys_clk_in),
    .rst_in(sys_rst_in),
    .strap_load_in(strap_load),
    .strap_prio_in(strap_prio),
    .wr_in(main_wr),
    .hit_a_in(hit_a),
    .hit_b_in(hit_b),
    .data_in(req.data),
    .bank_out(main_bank)
  );

  prio_copy #(
    .RST_11_12(`RST_AUX_11_12),
    .RST_13_14(`RST_AUX_13_14),
    .USE_STRAP(1'b0)
  ) u_aux_copy (
    .clk_in(sys_clk_in),
    .rst_in(sys_rst_in),
    .strap_load_in(strap_load),
    .strap_prio_in(strap_prio),
    .wr_in(aux_wr),
    .hit_a_in(hit_a),
    .hit_b_in(hit_b),
    .data_in(req.data),
    .bank_out(aux_bank)
  );

  prio_rank #(
    .NUM_IN(`NUM_INPUTS),
    .FIRST(`FIRST_INPUT)
  ) u_main_rank (
    .prio_in({main_bank.p13_14, main_bank.p11_12}),
    .pick_out(main_pick)
  );

  prio_rank #(
    .NUM_IN(`NUM_INPUTS),
    .FIRST(`FIRST_INPUT)
  ) u_aux_rank (
    .prio_in({aux_bank.p13_14, aux_bank.p11_12}),
    .pick_out(aux_pick)
  );

  // Unmapped addresses read back as zero
  always_comb begin
    rd_word = 8'h00;
    if (hit_a) begin
      rd_word = req.aux ? aux_bank.p11_12 : main_bank.p11_12;
    end else if (hit_b) begin
      rd_word = req.aux ? aux_bank.p13_14 : main_bank.p13_14;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      rd_data_out <= 8'h00;
    end else if (req.rd) begin
      rd_data_out <= rd_word;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      main_sel_valid_out <= 1'b0;
      main_sel_index_out <= 4'h0;
    end else begin
      main_sel_valid_out <= main_pick.valid;
      main_sel_index_out <= main_pick.index;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      aux_sel_valid_out <= 1'b0;
      aux_sel_index_out <= 4'h0;
    end else begin
      aux_sel_valid_out <= aux_pick.valid;
      aux_sel_index_out <= aux_pick.index;
    end
  end
endmodule

// One path's copy of the four priority fields
module prio_copy
  import ref_prio_pkg::*;
#(
  parameter logic [7:0] RST_11_12 = 8'h00,
  parameter logic [7:0] RST_13_14 = 8'h00,
  parameter logic USE_STRAP = 1'b0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic strap_load_in,
  input wire logic [3:0] strap_prio_in,
  input wire logic wr_in,
  input wire logic hit_a_in,
  input wire logic hit_b_in,
  input wire logic [7:0] data_in,
  output prio_bank_t bank_out
);
  prio_bank_t bank_q;

  assign bank_out = bank_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bank_q.p11_12 <= RST_11_12;
      bank_q.p13_14 <= RST_13_14;
    end else if (USE_STRAP && strap_load_in) begin
      bank_q.p11_12.lo <= strap_prio_in;
    end else if (wr_in) begin
      if (hit_a_in) begin
        bank_q.p11_12 <= data_in;
      end
      if (hit_b_in) begin
        bank_q.p13_14 <= data_in;
      end
    end
  end
endmodule

// Picks the winning input of one path
module prio_rank
  import ref_prio_pkg::*;
#(
  parameter int NUM_IN = 4,
  parameter logic [3:0] FIRST = 4'hb
) (
  input wire logic [4*NUM_IN-1:0] prio_in,
  output sel_result_t pick_out
);
  logic [3:0] best;
  logic [3:0] idx;
  logic found;

  // Lowest nonzero value wins; a tie goes to the lower input number
  always_comb begin
    best = 4'hf;
    idx = 4'h0;
    found = 1'b0;
    for (int i = 0; i < NUM_IN; i++) begin
      if (prio_in[i*4 +: 4] != `PRIO_OFF &&
          (!found || prio_in[i*4 +: 4] < best)) begin
        best = prio_in[i*4 +: 4];
        idx = 4'(i) + FIRST;
        found = 1'b1;
      end
    end
    pick_out.valid = found;
    pick_out.index = idx;
  end
endmodule

// [verification/prio_sva.sv]
`timescale 1ns/1ps
module prio_sva (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic path_bank_select_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic main_sel_valid_out,
  input wire logic aux_sel_valid_out,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [7:0] rd_data_out,
  input wire logic [3:0] main_sel_index_out,
  input wire logic [3:0] aux_sel_index_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_a(w, b, a);
    wr_en_in == w && rd_en_in != w && addr_in == a && path_bank_select_in == b;
  endsequence
  property p_win;
    main_sel_valid_out |-> main_sel_index_out inside {[4'hb:4'he]};
  endproperty
  a_win: assert property (p_win) else $error("bad winner");
  property p_off; !aux_sel_valid_out |-> aux_sel_index_out == 4'h0;
  endproperty
  a_off: assert property (p_off) else $error("index without valid");
  property p_main; s_a(1, 0, 8'h1d) ##1 s_a(0, 0, 8'h1d) |=>
    rd_data_out == $past(wr_data_in, 2); endproperty
  a_main: assert property (p_main) else $error("main readback");
  property p_aux; s_a(1, 1, 8'h1e) ##1 s_a(0, 1, 8'h1e) |=>
    rd_data_out == $past(wr_data_in, 2); endproperty
  a_aux: assert property (p_aux) else $error("aux readback");
  property p_strap; $fell(sys_rst_in) |-> ##2 main_sel_index_out == 4'hb;
  endproperty
  a_strap: assert property (p_strap) else $error("default winner");
  property p_map; rd_en_in && addr_in > 8'h1e |=> rd_data_out == 8'h00;
  endproperty
  a_map: assert property (p_map) else $error("unmapped read");
  property p_rst; $fell(sys_rst_in) |-> (!aux_sel_valid_out) [*2];
  endproperty
  a_rst: assert property (p_rst) else $error("aux not cleared");
  property p_iso; (wr_en_in && path_bank_select_in) [*2] |=>
    $stable(main_sel_index_out); endproperty
  a_iso: assert property (p_iso) else $error("main path disturbed");
  cover property (aux_sel_valid_out);
  cover property (main_sel_index_out == 4'he);
  cover property (s_a(0, 1, 8'h1e));
endmodule

// [verification/host_cpu.sv]
`timescale 1ns/1ps
module host_cpu (
  input wire logic clk_in,
  output logic wr_out,
  output logic rd_out,
  output logic bank_out,
  output logic [7:0] addr_out,
  output logic [7:0] data_out
);
  initial {wr_out, rd_out, bank_out, addr_out, data_out} = '0;
  // Strobes stay up, so consecutive calls run back to back
  task automatic xfer(input logic w, r, b, input logic [7:0] a, d);
    @(posedge clk_in);
    {wr_out, rd_out, bank_out, addr_out, data_out} <= {w, r, b, a, d};
  endtask
endmodule

// [verification/testbench.sv]
`timescale 1ns/1ps
module testbench;
  logic sys_clk_in = 0, sys_rst_in = 1, master_slave_strap_in = 1;
  logic path_bank_select_in, wr_en_in, rd_en_in, rd_seen = 0;
  logic main_sel_valid_out, aux_sel_valid_out;
  logic [7:0] addr_in, wr_data_in, rd_data_out, d;
  logic [3:0] main_sel_index_out, aux_sel_index_out;
  logic [7:0] exp_q[$];
  int num_errors = 0, comparisons = 0;
  input_reference_priority_config u_input_reference_priority_config (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .master_slave_strap_in(master_slave_strap_in),
    .path_bank_select_in(path_bank_select_in),
    .addr_in(addr_in),
    .wr_en_in(wr_en_in),
    .rd_en_in(rd_en_in),
    .wr_data_in(wr_data_in),
    .rd_data_out(rd_data_out),
    .main_sel_valid_out(main_sel_valid_out),
    .main_sel_index_out(main_sel_index_out),
    .aux_sel_valid_out(aux_sel_valid_out),
    .aux_sel_index_out(aux_sel_index_out)
  );
  host_cpu u_host_cpu (.clk_in(sys_clk_in), .wr_out(wr_en_in),
    .rd_out(rd_en_in), .bank_out(path_bank_select_in), .addr_out(addr_in),
    .data_out(wr_data_in));
  initial forever #50 sys_clk_in = ~sys_clk_in;
  task automatic chk(input logic [7:0] g, e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, b, input logic [7:0] a, v);
    if (!w) exp_q.push_back(v);
    u_host_cpu.xfer(w, !w, b, a, v);
  endtask
  task automatic idle(input int n);
    repeat (n) u_host_cpu.xfer('0, '0, '0, '0, '0);
  endtask
  always @(posedge sys_clk_in) begin
    rd_seen <= rd_en_in;
    if (rd_seen) chk(rd_data_out, exp_q.pop_front());
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h9ab0795c));
    for (int s = 1; s >= 0; s--) begin
      master_slave_strap_in <= s[0];
      sys_rst_in <= 1'b1;
      repeat (8) @(posedge sys_clk_in);
      sys_rst_in <= 1'b0;
      acc(0, 0, 8'h1d, s ? 8'hdc : 8'hd1);
      acc(0, 0, 8'h1e, 8'hfe);
      acc(0, 1, 8'h1e, 8'h00);
      idle(2);
      $display("reset test done");
    end
    d = 8'($urandom);
    acc(1, 0, 8'h1d, d);
    acc(0, 0, 8'h1d, d);
    acc(1, 1, 8'h1d, ~d);
    acc(1, 1, 8'h1e, d ^ 8'h5a);
    acc(0, 1, 8'h1e, d ^ 8'h5a);
    acc(0, 1, 8'h1d, ~d);
    acc(0, 0, 8'h1d, d);
    acc(0, 0, 8'h1f, 8'h00);
    $display("access test done");
    acc(1, 0, 8'h1d, 8'h00);
    acc(1, 0, 8'h1e, 8'h12);
    acc(1, 1, 8'h1d, 8'h30);
    acc(1, 1, 8'h1e, 8'h54);
    idle(3);
    #1 chk({3'h0, main_sel_valid_out, main_sel_index_out}, 8'h1e);
    chk({3'h0, aux_sel_valid_out, aux_sel_index_out}, 8'h1c);
    acc(1, 0, 8'h1e, 8'h00);
    idle(3);
    #1 chk({3'h0, main_sel_valid_out, main_sel_index_out}, 8'h00);
    chk({3'h0, aux_sel_valid_out, aux_sel_index_out}, 8'h1c);
    $display("ranking test done");
    complete_run();
  end
endmodule
bind input_reference_priority_config prio_sva u_prio_sva (
  .sys_clk_in(sys_clk_in),
  .sys_rst_in(sys_rst_in),
  .path_bank_select_in(path_bank_select_in),
  .wr_en_in(wr_en_in),
  .rd_en_in(rd_en_in),
  .main_sel_valid_out(main_sel_valid_out),
  .aux_sel_valid_out(aux_sel_valid_out),
  .addr_in(addr_in),
  .wr_data_in(wr_data_in),
  .rd_data_out(rd_data_out),
  .main_sel_index_out(main_sel_index_out),
  .aux_sel_index_out(aux_sel_index_out)
);
